// ===== design/rec_error_checker.sv
// rec_error_checker: error detection for a transceiver reconfiguration
// controller, with an Avalon-MM register port and one level interrupt.
// assumes user requests are synchronous to clk_sys and the datapath
// answers each started operation with a one-cycle opDone.
`timescale 1ns/1ns
`default_nettype none
module rec_error_checker
    import rec_pkg::*;
#(
    parameter bit ILLEGAL_CHECK = 1'b1,
    parameter bit SELF_RECOVERY = 1'b1,
    parameter bit AFE_RD_PORTS  = 1'b1,
    parameter bit AFE_WR_PORTS  = 1'b1
)
(
    input  wire logic        clk_sys,
    input  wire logic        sys_rst,
    input  wire logic        rdReq,
    input  wire logic        wrAllReq,
    input  wire logic [2:0]  modeSel,
    input  wire logic        opDone,
    output logic             busy,
    output logic             errOut,
    output logic             opStart,
    output logic             opAbort,
    output logic             irq,
    input  wire logic [2:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    output logic [31:0]      avs_readdata,
    output logic             avs_waitrequest
);

    localparam bit ERR_BUILT = ILLEGAL_CHECK || SELF_RECOVERY;

    rec_state_t  state_r;
    rec_state_t  state_nxt;
    logic [0:0]  errCnt_r;
    logic [0:0]  errCnt_nxt;
    logic        opRd_r;
    logic        opRd_nxt;
    logic        opWr_r;
    logic        opWr_nxt;
    logic [2:0]  mode_r;
    logic [2:0]  mode_nxt;
    logic [1:0]  cause_r;
    logic [1:0]  cause_nxt;
    logic        busy_r;
    logic        busy_nxt;
    logic        errOut_r;
    logic        errOut_nxt;
    logic        opStart_r;
    logic        opStart_nxt;
    logic        opAbort_r;
    logic        opAbort_nxt;
    logic [2:0]  events;

    logic [1:0]  ctrl_r;
    logic [1:0]  ctrl_nxt;
    logic [2:0]  irqStat_r;
    logic [2:0]  irqStat_nxt;
    logic [2:0]  mask_r;
    logic [2:0]  mask_nxt;
    logic [15:0] tout_r;
    logic [15:0] tout_nxt;
    logic        waitreq_r;
    logic        waitreq_nxt;
    logic [31:0] rdata_r;
    logic [31:0] rdata_nxt;
    logic        irq_r;
    logic        irq_nxt;
    logic        ilEn;
    logic        srEn;
    logic        accept;

    rec_wdog_if wdogIf ();

    rec_watchdog rec_watchdog_i
    (
        .clk_sys (clk_sys),
        .sys_rst (sys_rst),
        .wdog    (wdogIf.wd)
    );

    // only value-free checks exist: the data written never enters here
    function automatic logic isIllegal(input logic rd, input logic wr, input logic [2:0] mode);
        isIllegal = (rd && !AFE_RD_PORTS)
                  || (wr && !AFE_WR_PORTS)
                  || (rd && (mode == MODE_CHAN_RECFG));
    endfunction

    // built option and software enable must both be set
    assign ilEn   = ILLEGAL_CHECK && ctrl_r[CTRL_ILL_EN];
    assign srEn   = SELF_RECOVERY && ctrl_r[CTRL_SR_EN];
    assign accept = (state_r == ST_IDLE) && (rdReq || wrAllReq);

    assign wdogIf.run   = (state_r == ST_RUN);
    assign wdogIf.limit = tout_r;

    // operation state machine
    always_comb
    begin
        state_nxt   = state_r;
        errCnt_nxt  = errCnt_r;
        opRd_nxt    = opRd_r;
        opWr_nxt    = opWr_r;
        mode_nxt    = mode_r;
        cause_nxt   = cause_r;
        opStart_nxt = 1'b0;
        opAbort_nxt = 1'b0;
        events      = 3'h0;
        case (state_r)
            ST_IDLE:
            begin
                if (rdReq || wrAllReq)
                begin
                    // read wins if both strobes arrive together
                    state_nxt = ST_CHECK;
                    opRd_nxt  = rdReq;
                    opWr_nxt  = !rdReq && wrAllReq;
                    mode_nxt  = modeSel;
                end
            end
            ST_CHECK:
            begin
                if (ilEn && isIllegal(opRd_r, opWr_r, mode_r))
                begin
                    state_nxt        = ST_ERR;
                    errCnt_nxt       = 1'b0;
                    cause_nxt        = CAUSE_ILL;
                    events[EVT_ILL]  = 1'b1;
                end
                else
                begin
                    state_nxt   = ST_RUN;
                    opStart_nxt = 1'b1;
                end
            end
            ST_RUN:
            begin
                if (opDone)
                begin
                    state_nxt        = ST_IDLE;
                    cause_nxt        = CAUSE_NONE;
                    events[EVT_DONE] = 1'b1;
                end
                else if (srEn && wdogIf.expired)
                begin
                    state_nxt        = ST_ERR;
                    errCnt_nxt       = 1'b0;
                    opAbort_nxt      = 1'b1;
                    cause_nxt        = CAUSE_TOUT;
                    events[EVT_TOUT] = 1'b1;
                end
            end
            ST_ERR:
            begin
                if (errCnt_r == ERR_CNT_LAST)
                begin
                    state_nxt = ST_IDLE;
                end
                else
                begin
                    errCnt_nxt = errCnt_r + 1'b1;
                end
            end
            default:
            begin
                state_nxt = ST_IDLE;
            end
        endcase
        busy_nxt   = (state_nxt == ST_CHECK) || (state_nxt == ST_RUN);
        errOut_nxt = ERR_BUILT && (state_nxt == ST_ERR);
    end

    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            state_r   <= ST_IDLE;
            errCnt_r  <= 1'b0;
            opRd_r    <= 1'b0;
            opWr_r    <= 1'b0;
            mode_r    <= 3'h0;
            cause_r   <= CAUSE_NONE;
            busy_r    <= 1'b0;
            errOut_r  <= 1'b0;
            opStart_r <= 1'b0;
            opAbort_r <= 1'b0;
        end
        else
        begin
            state_r   <= state_nxt;
            errCnt_r  <= errCnt_nxt;
            opRd_r    <= opRd_nxt;
            opWr_r    <= opWr_nxt;
            mode_r    <= mode_nxt;
            cause_r   <= cause_nxt;
            busy_r    <= busy_nxt;
            errOut_r  <= errOut_nxt;
            opStart_r <= opStart_nxt;
            opAbort_r <= opAbort_nxt;
        end
    end

    // register port: one wait cycle on every access, then the answer
    always_comb
    begin
        ctrl_nxt    = ctrl_r;
        mask_nxt    = mask_r;
        tout_nxt    = tout_r;
        rdata_nxt   = rdata_r;
        irqStat_nxt = irqStat_r;
        waitreq_nxt = !(waitreq_r && (avs_read || avs_write));
        if (avs_write && !waitreq_r)
        begin
            if (avs_address == REG_CTRL)
            begin
                ctrl_nxt = avs_writedata[1:0];
            end
            else if (avs_address == REG_IRQ)
            begin
                irqStat_nxt = irqStat_r & ~avs_writedata[2:0];
            end
            else if (avs_address == REG_MASK)
            begin
                mask_nxt = avs_writedata[2:0];
            end
            else if (avs_address == REG_TOUT)
            begin
                // zero would expire at once, so clamp to the minimum
                tout_nxt = (avs_writedata[15:0] < TOUT_MIN) ? TOUT_MIN : avs_writedata[15:0];
            end
        end
        // a new event beats a clear in the same cycle
        irqStat_nxt = irqStat_nxt | events;
        if (avs_read && waitreq_r)
        begin
            rdata_nxt = 32'h0000_0000;
            if (avs_address == REG_CTRL)
            begin
                rdata_nxt[1:0] = ctrl_r;
            end
            else if (avs_address == REG_STAT)
            begin
                rdata_nxt[STAT_BUSY]                        = busy_r;
                rdata_nxt[STAT_ERR]                         = errOut_r;
                rdata_nxt[STAT_STATE_LSB+1:STAT_STATE_LSB] = state_r;
                rdata_nxt[STAT_CAUSE_LSB+1:STAT_CAUSE_LSB] = cause_r;
            end
            else if (avs_address == REG_IRQ)
            begin
                rdata_nxt[2:0] = irqStat_r;
            end
            else if (avs_address == REG_MASK)
            begin
                rdata_nxt[2:0] = mask_r;
            end
            else if (avs_address == REG_TOUT)
            begin
                rdata_nxt[15:0] = tout_r;
            end
        end
        irq_nxt = |(irqStat_nxt & mask_nxt);
    end

    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            ctrl_r    <= CTRL_RST;
            irqStat_r <= IRQ_RST;
            mask_r    <= MASK_RST;
            tout_r    <= TOUT_RST;
            waitreq_r <= 1'b1;
            rdata_r   <= 32'h0000_0000;
            irq_r     <= 1'b0;
        end
        else
        begin
            ctrl_r    <= ctrl_nxt;
            irqStat_r <= irqStat_nxt;
            mask_r    <= mask_nxt;
            tout_r    <= tout_nxt;
            waitreq_r <= waitreq_nxt;
            rdata_r   <= rdata_nxt;
            irq_r     <= irq_nxt;
        end
    end

    assign busy            = busy_r;
    assign errOut          = errOut_r;
    assign opStart         = opStart_r;
    assign opAbort         = opAbort_r;
    assign irq             = irq_r;
    assign avs_readdata    = rdata_r;
    assign avs_waitrequest = waitreq_r;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (sys_rst);

    property p_no_err_unbuilt;
        !ERR_BUILT |-> !errOut_r;
    endproperty
    a_no_err_unbuilt: assert property (p_no_err_unbuilt) else $error("error raised without option");

    property p_ill_detect;
        accept && ilEn && isIllegal(rdReq, !rdReq && wrAllReq, modeSel) |-> ##2 (errOut_r && !busy_r);
    endproperty
    a_ill_detect: assert property (p_ill_detect) else $error("illegal request not flagged in time");

    property p_err_len;
        $rose(errOut_r) |-> errOut_r ##1 errOut_r ##1 !errOut_r;
    endproperty
    a_err_len: assert property (p_err_len) else $error("error pulse not two cycles");

    property p_afe_rd;
        accept && ilEn && rdReq && !AFE_RD_PORTS |-> ##2 errOut_r;
    endproperty
    a_afe_rd: assert property (p_afe_rd) else $error("read without readback ports not flagged");

    property p_afe_wr;
        accept && ilEn && !rdReq && wrAllReq && !AFE_WR_PORTS |-> ##2 errOut_r;
    endproperty
    a_afe_wr: assert property (p_afe_wr) else $error("write-all without setting ports not flagged");

    property p_chan_rd;
        accept && ilEn && rdReq && (modeSel == MODE_CHAN_RECFG) |-> ##2 errOut_r;
    endproperty
    a_chan_rd: assert property (p_chan_rd) else $error("read in channel mode not flagged");

    property p_tout_abort;
        (state_r == ST_RUN) && !opDone && srEn && wdogIf.expired |=> opAbort_r && (state_r == ST_ERR);
    endproperty
    a_tout_abort: assert property (p_tout_abort) else $error("overrun operation not abandoned");

    property p_abort_err;
        $rose(opAbort_r) |-> (errOut_r && !busy_r) ##2 !errOut_r;
    endproperty
    a_abort_err: assert property (p_abort_err) else $error("abort without two-cycle error");

    property p_legal_ok;
        accept && !(ilEn && isIllegal(rdReq, !rdReq && wrAllReq, modeSel)) |=> busy_r ##1 (opStart_r && !errOut_r);
    endproperty
    a_legal_ok: assert property (p_legal_ok) else $error("legal request raised error");

    property p_busy_excl;
        !(busy_r && errOut_r);
    endproperty
    a_busy_excl: assert property (p_busy_excl) else $error("busy and error high together");

endmodule // rec_error_checker
`default_nettype wire

// ===== design/rec_pkg.sv
// rec_pkg: register map, field positions, reset values and state encoding
// shared by the reconfiguration error checker and its watchdog.
// assumes a 20 MHz clk_sys and a word-addressed Avalon-MM slave port.
package rec_pkg;

    localparam int CLK_SYS_HZ = 20_000_000;

    // word addresses on the register port
    localparam logic [2:0] REG_CTRL = 3'h0;
    localparam logic [2:0] REG_STAT = 3'h1;
    localparam logic [2:0] REG_IRQ  = 3'h2;
    localparam logic [2:0] REG_MASK = 3'h3;
    localparam logic [2:0] REG_TOUT = 3'h4;

    // control fields
    localparam int         CTRL_ILL_EN = 0;
    localparam int         CTRL_SR_EN  = 1;
    localparam logic [1:0] CTRL_RST    = 2'h3;

    // event bits, shared by irq status and irq mask
    localparam int         EVT_ILL  = 0;
    localparam int         EVT_TOUT = 1;
    localparam int         EVT_DONE = 2;
    localparam logic [2:0] IRQ_RST  = 3'h0;
    localparam logic [2:0] MASK_RST = 3'h0;

    // status fields
    localparam int STAT_BUSY      = 0;
    localparam int STAT_ERR       = 1;
    localparam int STAT_STATE_LSB = 2;
    localparam int STAT_CAUSE_LSB = 4;

    localparam logic [1:0] CAUSE_NONE = 2'h0;
    localparam logic [1:0] CAUSE_ILL  = 2'h1;
    localparam logic [1:0] CAUSE_TOUT = 2'h2;

    // expected operation length in clk_sys cycles
    localparam logic [15:0] TOUT_RST = 16'h0400;
    localparam logic [15:0] TOUT_MIN = 16'h0001;

    localparam logic [2:0] MODE_CHAN_RECFG = 3'h1;

    localparam int         ERR_PULSE_CYC = 2;
    localparam logic [0:0] ERR_CNT_LAST  = 1'(ERR_PULSE_CYC - 1);

    typedef enum logic [1:0]
    {
        ST_IDLE  = 2'h0,
        ST_CHECK = 2'h1,
        ST_RUN   = 2'h3,
        ST_ERR   = 2'h2
    } rec_state_t;

endpackage

// ===== design/rec_wdog_if.sv
// rec_wdog_if: link between the checker and its operation watchdog.
// assumes both ends run on clk_sys.
`timescale 1ns/1ns
`default_nettype none
interface rec_wdog_if;
    logic        run;
    logic [15:0] limit;
    logic        expired;

    modport ctl (output run, output limit, input expired);
    modport wd  (input run, input limit, output expired);
endinterface
`default_nettype wire

// ===== design/rec_watchdog.sv
// rec_watchdog: counts cycles while an operation runs and flags overrun.
// assumes limit is at least one and stable while run is high.
`timescale 1ns/1ns
`default_nettype none
module rec_watchdog
    import rec_pkg::*;
(
    input  wire logic clk_sys,
    input  wire logic sys_rst,
    rec_wdog_if.wd    wdog
);

    logic [15:0] cnt_r;
    logic [15:0] cnt_nxt;
    logic        expired_r;
    logic        expired_nxt;

    always_comb
    begin
        cnt_nxt     = cnt_r;
        expired_nxt = 1'b0;
        if (!wdog.run)
        begin
            cnt_nxt = 16'h0000;
        end
        else
        begin
            // saturate so a stalled op never wraps back under the limit
            if (cnt_r != 16'hFFFF)
            begin
                cnt_nxt = cnt_r + 16'h0001;
            end
            expired_nxt = (cnt_nxt >= wdog.limit);
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            cnt_r     <= 16'h0000;
            expired_r <= 1'b0;
        end
        else
        begin
            cnt_r     <= cnt_nxt;
            expired_r <= expired_nxt;
        end
    end

    assign wdog.expired = expired_r;

    property p_wdog_quiet;
        @(posedge clk_sys) disable iff (sys_rst)
        !wdog.run |=> !wdog.expired;
    endproperty
    a_wdog_quiet: assert property (p_wdog_quiet) else $error("watchdog expired while idle");

endmodule // rec_watchdog
`default_nettype wire

// ===== tb/rec_user_model.sv
// rec_user_model: user logic issuing reconfiguration requests, and the
// datapath answering each opStart with a one-cycle opDone, unless the request was issued with dly 0 or opAbort comes first.
// assumes the checker and this model share clk_sys; the bench calls issue().
`timescale 1ns/1ns
`default_nettype none
module rec_user_model (
    input  wire logic      clk_sys,
    input  wire logic      sys_rst,
    input  wire logic      opStart,
    input  wire logic      opAbort,
    output var logic       rdReq,
    output var logic       wrAllReq,
    output var logic [2:0] modeSel,
    output var logic       opDone
);
    int doneDly = 0;
    int doneCnt = 0;

    initial
    begin
        rdReq    = 1'b0;
        wrAllReq = 1'b0;
        modeSel  = 3'h0;
        opDone   = 1'b0;
    end

    // one-cycle request; dly 0 means the datapath never answers
    task automatic issue(input logic rd, input logic [2:0] mode, input int dly);
        @(posedge clk_sys);
        rdReq    <= rd;
        wrAllReq <= ~rd;
        modeSel  <= mode;
        doneDly  <= dly;
        @(posedge clk_sys);
        rdReq    <= 1'b0;
        wrAllReq <= 1'b0;
        // select is meaningless outside a request, so it must not linger
        modeSel  <= ~mode;
    endtask

    always @(posedge clk_sys)
    begin
        opDone <= 1'b0;
        if (sys_rst || opAbort)
            doneCnt <= 0;
        else if (opStart && doneDly > 0)
            doneCnt <= doneDly;
        else if (doneCnt == 1)
        begin
            opDone  <= 1'b1;
            doneCnt <= 0;
        end
        else if (doneCnt > 1)
            doneCnt <= doneCnt - 1;
    end
endmodule // rec_user_model
`default_nettype wire

// ===== tb/rec_error_checker_test.sv
// rec_error_checker_test: self-checking bench for the error checker.
// assumes three checker builds share the user and register inputs:
// full, without analog front-end ports, and with neither check built.
`timescale 1ns/1ns
`default_nettype none
module rec_error_checker_test;
    import rec_pkg::*;

    logic        clk_sys = 1'b0;
    logic        sys_rst = 1'b1;
    logic        rdReq, wrAllReq, opDone;
    logic [2:0]  modeSel;
    logic        busy, errOut, opStart, opAbort, irq, afeErr, bareErr;
    logic [2:0]  avs_address = 3'h0;
    logic        avs_read = 1'b0;
    logic        avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [31:0] avs_readdata;
    logic [31:0] rd = 32'h0;
    logic        avs_waitrequest;
    int          errCount = 0, nChecks = 0, n = 0;
    int          errMain = 0, errAfe = 0, errBare = 0, nStart = 0, badDone = 0;
    logic [2:0]  regAddr [6] = '{REG_CTRL, REG_STAT, REG_IRQ, REG_MASK, REG_TOUT, 3'h5};
    logic [31:0] regVal [6] = '{32'(CTRL_RST), 32'h0, 32'(IRQ_RST), 32'(MASK_RST), 32'(TOUT_RST), 32'h0};

    always #25 clk_sys = ~clk_sys;

    rec_error_checker rec_error_checker_i (
        .clk_sys(clk_sys), .sys_rst(sys_rst), .rdReq(rdReq), .wrAllReq(wrAllReq), .modeSel(modeSel),
        .opDone(opDone), .busy(busy), .errOut(errOut), .opStart(opStart), .opAbort(opAbort), .irq(irq),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));
    rec_error_checker #(.AFE_RD_PORTS(1'b0), .AFE_WR_PORTS(1'b0)) rec_error_checker_afe_i (
        .clk_sys(clk_sys), .sys_rst(sys_rst), .rdReq(rdReq), .wrAllReq(wrAllReq), .modeSel(modeSel),
        .opDone(opDone), .busy(), .errOut(afeErr), .opStart(), .opAbort(), .irq(),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_readdata(), .avs_waitrequest());
    rec_error_checker #(.ILLEGAL_CHECK(1'b0), .SELF_RECOVERY(1'b0))
        rec_error_checker_bare_i (
        .clk_sys(clk_sys), .sys_rst(sys_rst), .rdReq(rdReq), .wrAllReq(wrAllReq), .modeSel(modeSel),
        .opDone(opDone), .busy(), .errOut(bareErr), .opStart(), .opAbort(), .irq(),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_readdata(), .avs_waitrequest());
    rec_user_model user_i (
        .clk_sys(clk_sys), .sys_rst(sys_rst), .opStart(opStart), .opAbort(opAbort),
        .rdReq(rdReq), .wrAllReq(wrAllReq), .modeSel(modeSel), .opDone(opDone));

    // per-cycle tallies, sampled mid-cycle where outputs are settled
    always @(negedge clk_sys)
    begin
        errMain += int'(errOut === 1'b1);
        errAfe  += int'(afeErr === 1'b1);
        errBare += int'(bareErr === 1'b1);
        nStart  += int'(opStart === 1'b1);
        badDone += int'(opDone === 1'b1 && busy !== 1'b1);
    end

    task automatic complete_run();
        $display("checks %0d, mismatches %0d", nChecks, errCount);
        if (errCount == 0 && nChecks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        nChecks++;
        if (seen !== exp)
        begin
            errCount++;
            $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
        end
    endtask

    task automatic clr();
        errMain = 0;
        errAfe  = 0;
        nStart  = 0;
        badDone = 0;
    endtask

    // one Avalon-MM access, held until waitrequest is seen low
    task automatic bus(input logic wr, input logic [2:0] a, input logic [31:0] d);
        int k;
        @(posedge clk_sys);
        avs_address   <= a;
        avs_writedata <= d;
        avs_read      <= ~wr;
        avs_write     <= wr;
        k = 0;
        // waitrequest and readdata are taken at the same rising edge
        do
        begin
            @(posedge clk_sys);
            k++;
        end
        while (avs_waitrequest !== 1'b0 && k < 20);
        rd = avs_readdata;
        avs_read  <= 1'b0;
        avs_write <= 1'b0;
        if (k >= 20)
        begin
            errCount++;
            $display("unexpected at %0t: bus never answered", $time);
            complete_run();
        end
    endtask

    task automatic rchk(input logic [2:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask

    task automatic wait_idle();
        int k;
        k = 0;
        do
        begin
            @(negedge clk_sys);
            k++;
        end
        while ((busy !== 1'b0 || errOut !== 1'b0) && k < 100);
        chk(32'(k < 100), 32'h1);
    endtask

    initial
    begin
        repeat (8) @(posedge clk_sys);
        sys_rst <= 1'b0;
        @(posedge clk_sys);
        @(negedge clk_sys);
        chk(32'({busy, errOut, irq}), 32'h0);
        for (int i = 0; i < 6; i++)
            rchk(regAddr[i], regVal[i]);
        bus(1'b1, REG_TOUT, 32'h0);
        rchk(REG_TOUT, 32'(TOUT_MIN));
        bus(1'b1, REG_TOUT, 32'h4);
        bus(1'b1, REG_MASK, 32'h7);
        user_i.issue(1'b1, MODE_CHAN_RECFG, 0);
        @(negedge clk_sys);
        chk(32'({busy, errOut}), 32'h2);
        @(negedge clk_sys);
        chk(32'({busy, errOut, afeErr, bareErr}), 32'h6);
        @(negedge clk_sys);
        chk(32'({busy, errOut}), 32'h1);
        @(negedge clk_sys);
        chk(32'({errOut, irq}), 32'h1);
        rchk(REG_IRQ, 32'h1);
        bus(1'b1, REG_IRQ, 32'h1);
        rchk(REG_IRQ, 32'h0);
        chk(32'(irq), 32'h0);
        for (int m = 0; m < 8; m++)
        begin
            clr();
            user_i.issue(1'b1, 3'(m), 1);
            wait_idle();
            chk(errMain, (m == 1) ? 2 : 0);
            chk(errAfe, 2);
            chk(nStart, (m == 1) ? 0 : 1);
            clr();
            user_i.issue(1'b0, 3'(m), 1);
            wait_idle();
            chk(errMain, 0);
            chk(errAfe, 2);
        end
        bus(1'b1, REG_IRQ, 32'h7);
        clr();
        // answer lands on the expiry edge, so done must win; a second request is dropped
        user_i.issue(1'b1, 3'h0, 3);
        user_i.issue(1'b1, MODE_CHAN_RECFG, 3);
        wait_idle();
        chk(errMain, 0);
        chk(nStart, 1);
        chk(badDone, 0);
        rchk(REG_IRQ, 32'h4);
        bus(1'b1, REG_CTRL, 32'h2);
        clr();
        user_i.issue(1'b1, MODE_CHAN_RECFG, 2);
        wait_idle();
        chk(errMain, 0);
        chk(nStart, 1);
        bus(1'b1, REG_CTRL, 32'h3);
        bus(1'b1, REG_IRQ, 32'h7);
        user_i.issue(1'b0, 3'h0, 0);
        n = 0;
        while (opStart !== 1'b1 && n < 10)
        begin
            @(negedge clk_sys);
            n++;
        end
        chk(32'(n < 10), 32'h1);
        n = 0;
        while (opAbort !== 1'b1 && n < 50)
        begin
            @(negedge clk_sys);
            n++;
        end
        chk(n, 5);
        chk(32'({busy, errOut}), 32'h1);
        @(negedge clk_sys);
        chk(32'({busy, errOut, opAbort}), 32'h2);
        @(negedge clk_sys);
        chk(32'(errOut), 32'h0);
        rchk(REG_IRQ, 32'h2);
        rchk(REG_STAT, 32'h20);
        chk(32'(irq), 32'h1);
        bus(1'b1, REG_MASK, 32'h5);
        rchk(REG_MASK, 32'h5);
        chk(32'(irq), 32'h0);
        chk(errBare, 0);
        complete_run();
    end
endmodule // rec_error_checker_test
`default_nettype wire
